// >>> shared/sse_params.svh
// constants for the power-down and subtract-from-literal execution block
// assumes one core clock of 10 MHz split into four quarter-cycles
`ifndef SSE_PARAMS_SVH
`define SSE_PARAMS_SVH

// instruction word and opcode patterns
`define SSE_IW 14
`define SSE_SLEEP_CODE 14'h0063
`define SSE_SUBL_TOP_MSB 13
`define SSE_SUBL_TOP_LSB 9
`define SSE_SUBL_TOP 5'h1E
`define SSE_LIT_MSB 7

// reset values of the core state this block owns
`define SSE_W_RST 8'h00
`define SSE_TO_RST 1'b1
`define SSE_PD_RST 1'b1
`define SSE_C_RST 1'b0
`define SSE_DC_RST 1'b0
`define SSE_Z_RST 1'b0

// value loaded into the watchdog counter by the power-down instruction
`define SSE_WDT_CLR_VAL 8'h00

// core clock period and instruction cycle length in clock edges
`define SSE_CLK_NS 100
`define SSE_QPER_CYC 4

`endif

// >>> shared/sse_pkg.sv
// types shared by the execution block and its arithmetic unit
// assumes sse_params.svh is on the include path
package sse_pkg;

	// quarter-cycles of one instruction cycle
	typedef enum logic [1:0] {
		SSE_Q1,
		SSE_Q2,
		SSE_Q3,
		SSE_Q4
	} sse_phase_t;

	// what the decoder made of the fetched word
	typedef struct packed {
		logic is_sleep;
		logic is_subl;
		logic [7:0] literal;
	} sse_dec_t;

	// arithmetic status bits touched by the subtraction
	typedef struct packed {
		logic carry;
		logic digit_carry;
		logic zero;
	} sse_flags_t;

	// power status bits touched by the power-down instruction
	typedef struct packed {
		logic time_out_flag;
		logic power_down_flag;
	} sse_pwr_t;

endpackage

// >>> src/sse_sub_alu.sv
// eight-bit literal minus working register with status flags
// assumes operands are stable registers; result is purely combinational
module sse_sub_alu
	import sse_pkg::*;
(
	input wire logic [7:0] i_lit,
	input wire logic [7:0] i_w,
	output logic [7:0] o_diff,
	output sse_flags_t o_flags
);

	logic [8:0] full;
	logic [4:0] low;

	// two's complement: lit + ~w + 1, carry out is the inverted borrow
	always_comb begin
		full = {1'b0, i_lit} + {1'b0, ~i_w} + 9'h001;
		low = {1'b0, i_lit[3:0]} + {1'b0, ~i_w[3:0]} + 5'h01;
		o_diff = full[7:0];
		o_flags.carry = full[8];
		o_flags.digit_carry = low[4];
		o_flags.zero = (full[7:0] == 8'h00);
	end

endmodule

// >>> src/sse_core.sv
// execution of the power-down and subtract-from-literal instructions
// assumes the fetch unit presents a word at the first quarter-cycle and
// that the clock logic halts the oscillator while o_sleep is high
`include "sse_params.svh"

// What this block does
// - The word 00 0000 0110 0011 is decoded as power-down, with no operands.
// - Power-down clears the power-down flag to 0.
// - Power-down sets the time-out flag to 1.
// - Power-down resets the watchdog counter to 00h and its prescaler.
// - After power-down the core sits in low-power state, oscillator halted.
// - Power-down decodes in Q1, idles in Q2 and Q3, sleeps in Q4.
// - Subtract-from-literal forms literal minus W in two's complement.
// - The 8-bit difference goes to the working register only.
// - Subtract-from-literal updates carry, digit carry and zero.
// - Carry is the inverted borrow and zero is set only for a zero result.
// - Subtract decodes in Q1, reads in Q2, computes in Q3, writes W in Q4.
module sse_core
	import sse_pkg::*;
#(
	parameter int QUARTERS = `SSE_QPER_CYC
)(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_instr_valid,
	input wire logic [`SSE_IW-1:0] i_instr,
	input wire logic i_wake,
	input wire logic i_w_load,
	input wire logic [7:0] i_w_data,
	input wire logic i_flags_load,
	input wire sse_flags_t i_flags_data,
	output sse_phase_t o_phase,
	output logic [7:0] o_w,
	output sse_flags_t o_flags,
	output sse_pwr_t o_pwr,
	output logic o_watchdog_clear,
	output logic [7:0] o_watchdog_counter_val,
	output logic o_sleep,
	output logic o_osc_halt,
	output logic o_cycle_done,
	output logic o_handled
);

	sse_phase_t phase_q, phase_d;
	sse_dec_t dec_q, dec_d;
	logic [7:0] lit_q, lit_d;
	logic [7:0] res_q, res_d;
	sse_flags_t rflags_q, rflags_d;
	logic [7:0] w_q, w_d;
	sse_flags_t flags_q, flags_d;
	sse_pwr_t pwr_q, pwr_d;
	logic wdt_clr_q, wdt_clr_d;
	logic sleep_q, sleep_d;
	logic done_q, done_d;
	logic handled_q, handled_d;
	logic [7:0] alu_diff;
	sse_flags_t alu_flags;
	sse_dec_t dec_now;
	logic [7:0] wdt_val_q;

	// subtraction unit fed only from registered operands
	sse_sub_alu u_alu (
		.i_lit(lit_q),
		.i_w(w_q),
		.o_diff(alu_diff),
		.o_flags(alu_flags)
	);

	// combinational decode of the presented word
	always_comb begin
		dec_now.is_sleep = (i_instr == `SSE_SLEEP_CODE);
		dec_now.is_subl = (i_instr[`SSE_SUBL_TOP_MSB:`SSE_SUBL_TOP_LSB]
			== `SSE_SUBL_TOP);
		dec_now.literal = i_instr[`SSE_LIT_MSB:0];
	end

	// quarter-cycle sequencer; frozen while asleep since the clock stops
	always_comb begin
		phase_d = phase_q;
		if (sleep_q) begin
			phase_d = SSE_Q1;
		end else begin
			case (phase_q)
				SSE_Q1: phase_d = SSE_Q2;
				SSE_Q2: phase_d = SSE_Q3;
				SSE_Q3: phase_d = SSE_Q4;
				SSE_Q4: phase_d = SSE_Q1;
				default: phase_d = SSE_Q1;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			phase_q <= SSE_Q1;
		end else begin
			phase_q <= phase_d;
		end
	end

	// latch the decode at Q1; a word without valid is treated as neither
	always_comb begin
		dec_d = dec_q;
		if (!sleep_q && phase_q == SSE_Q1) begin
			if (i_instr_valid) begin
				dec_d = dec_now;
			end else begin
				dec_d = '0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			dec_q <= '0;
		end else begin
			dec_q <= dec_d;
		end
	end

	// operand read in Q2, result captured in Q3
	// capturing in Q3 keeps the adder path off the W write in Q4
	always_comb begin
		lit_d = lit_q;
		res_d = res_q;
		rflags_d = rflags_q;
		if (!sleep_q && dec_q.is_subl) begin
			if (phase_q == SSE_Q2) begin
				lit_d = dec_q.literal;
			end
			if (phase_q == SSE_Q3) begin
				res_d = alu_diff;
				rflags_d = alu_flags;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lit_q <= 8'h00;
			res_q <= 8'h00;
			rflags_q <= '0;
		end else begin
			lit_q <= lit_d;
			res_q <= res_d;
			rflags_q <= rflags_d;
		end
	end

	// working register and arithmetic flags
	// the block's own Q4 write wins over a load from the rest of the core
	always_comb begin
		w_d = w_q;
		flags_d = flags_q;
		if (i_w_load) begin
			w_d = i_w_data;
		end
		if (i_flags_load) begin
			flags_d = i_flags_data;
		end
		if (!sleep_q && phase_q == SSE_Q4 && dec_q.is_subl) begin
			w_d = res_q;
			flags_d = rflags_q;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			w_q <= `SSE_W_RST;
			flags_q <= '{carry: `SSE_C_RST, digit_carry: `SSE_DC_RST,
				zero: `SSE_Z_RST};
		end else begin
			w_q <= w_d;
			flags_q <= flags_d;
		end
	end

	// power-down: flags, watchdog clear and sleep entry all at Q4
	// wake-up only leaves sleep; the power flags keep their values
	always_comb begin
		pwr_d = pwr_q;
		wdt_clr_d = 1'b0;
		sleep_d = sleep_q;
		if (sleep_q) begin
			if (i_wake) begin
				sleep_d = 1'b0;
			end
		end else if (phase_q == SSE_Q4 && dec_q.is_sleep) begin
			pwr_d.power_down_flag = 1'b0;
			pwr_d.time_out_flag = 1'b1;
			wdt_clr_d = 1'b1;
			sleep_d = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pwr_q <= '{time_out_flag: `SSE_TO_RST,
				power_down_flag: `SSE_PD_RST};
			wdt_clr_q <= 1'b0;
			sleep_q <= 1'b0;
			wdt_val_q <= `SSE_WDT_CLR_VAL;
		end else begin
			wdt_val_q <= `SSE_WDT_CLR_VAL;
			pwr_q <= pwr_d;
			wdt_clr_q <= wdt_clr_d;
			sleep_q <= sleep_d;
		end
	end

	// end-of-cycle pulse and whether this block executed the word
	always_comb begin
		done_d = 1'b0;
		handled_d = handled_q;
		if (!sleep_q && phase_q == SSE_Q4) begin
			done_d = 1'b1;
			handled_d = dec_q.is_sleep | dec_q.is_subl;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			done_q <= 1'b0;
			handled_q <= 1'b0;
		end else begin
			done_q <= done_d;
			handled_q <= handled_d;
		end
	end

	// all outputs straight from flops
	assign o_phase = phase_q;
	assign o_w = w_q;
	assign o_flags = flags_q;
	assign o_pwr = pwr_q;
	assign o_watchdog_clear = wdt_clr_q;
	// counter and prescaler are cleared together; the count value is fixed
	assign o_watchdog_counter_val = wdt_val_q;
	assign o_sleep = sleep_q;
	assign o_osc_halt = sleep_q;
	assign o_cycle_done = done_q;
	assign o_handled = handled_q;

endmodule

// >>> testbench/sse_core_properties.sv
// checker for sse_core, bound at the foot
// assumes one clock and async low reset
module sse_core_properties
	import sse_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_instr_valid,
	input wire logic [13:0] i_instr,
	input wire logic i_wake,
	input wire sse_phase_t o_phase,
	input wire logic [7:0] o_w,
	input wire sse_flags_t o_flags,
	input wire sse_pwr_t o_pwr,
	input wire logic o_watchdog_clear,
	input wire logic [7:0] o_watchdog_counter_val,
	input wire logic o_sleep,
	input wire logic o_osc_halt,
	input wire logic o_cycle_done
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// a word counts only when taken at Q1 while awake
	wire tk = o_phase == SSE_Q1 && !o_sleep && i_instr_valid;
	wire sl = tk && i_instr == 14'h0063;
	wire sb = tk && i_instr[13:9] == 5'h1E;
	property sub_p;
		logic [7:0] k, w;
		(sb, k = i_instr[7:0], w = o_w) |-> ##4 o_w == 8'(k - w) &&
			o_flags == {k >= w, k[3:0] >= w[3:0], k == w};
	endproperty
	sub_res_a: assert property (sub_p)
		else $error("bad difference");
	sleep_go_a: assert property (sl |-> ##4 o_sleep &&
		o_watchdog_clear && o_pwr == 2'h2 && $stable(o_w))
		else $error("bad power-down");
	sleep_early_a: assert property (sl |-> ##3 !o_sleep)
		else $error("early sleep");
	only_w_a: assert property (sb |-> ##4 $stable(o_pwr))
		else $error("power flags moved");
	wd_clear_a: assert property (o_watchdog_clear |->
		o_watchdog_counter_val == 8'h00 ##1 !o_watchdog_clear)
		else $error("bad clear");
	osc_halt_a: assert property (o_osc_halt == o_sleep)
		else $error("osc running");
	stay_asleep_a: assert property (o_sleep && !i_wake |=>
		o_sleep && o_phase == SSE_Q1) else $error("left sleep");
	one_cycle_a: assert property (tk |-> ##4 o_cycle_done)
		else $error("long cycle");
	cover property (sl);
	cover property (sb && i_instr[8]);
	cover property (o_sleep && i_wake);
endmodule
bind sse_core sse_core_properties u_props (.i_clk, .i_rstn, .i_instr_valid,
	.i_instr, .i_wake, .o_phase, .o_w, .o_flags, .o_pwr, .o_watchdog_clear,
	.o_watchdog_counter_val, .o_sleep, .o_osc_halt, .o_cycle_done);

// >>> testbench/sse_fetch_model.sv
// fetch unit model: queued words offered at Q1
// assumes put is called outside Q1
module sse_fetch_model
	import sse_pkg::*;
(
	input wire logic i_clk,
	input wire sse_phase_t i_phase,
	input wire logic i_sleep,
	output logic o_valid,
	output logic [13:0] o_instr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [13:0] q[$];
	task put(input logic [13:0] w);
		q.push_back(w);
	endtask
	initial o_instr = 14'h0000;
	// no word offered before the first edge
	initial o_valid = 1'b0;
	// outside Q1 the word toggles so a stale one never passes
	always @(posedge i_clk) begin
		#1;
		o_valid = i_phase == SSE_Q1 && !i_sleep && q.size() > 0;
		o_instr = o_valid ? q.pop_front() : ~o_instr;
	end
endmodule

// >>> testbench/testbench.sv
// bench for sse_core fed by the fetch model
// assumes a 100 ns core clock
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 1'h0, i_rstn = 1'h0, i_wake = 1'h0;
	logic i_w_load = 1'h0, i_flags_load = 1'h0;
	logic [7:0] i_w_data = 8'h00, o_w, o_watchdog_counter_val, k, w, d;
	logic [2:0] i_flags_data = 3'h0, f;
	logic vld, o_watchdog_clear, o_sleep, o_osc_halt, o_cycle_done, o_handled;
	logic [13:0] ins;
	logic [15:0] tv [6] = '{16'h0201, 16'h0202, 16'h0203, 16'h1001,
		16'hFF00, 16'h00FF};
	sse_pkg::sse_phase_t o_phase;
	sse_pkg::sse_flags_t o_flags;
	sse_pkg::sse_pwr_t o_pwr;
	int err_total = 0, n_compared = 0, nclr;
	always #50 i_clk = ~i_clk;
	sse_core u_sse_core (.i_clk, .i_rstn, .i_instr_valid(vld), .i_instr(ins),
		.i_wake, .i_w_load, .i_w_data, .i_flags_load, .i_flags_data, .o_phase,
		.o_w, .o_flags, .o_pwr, .o_watchdog_clear, .o_watchdog_counter_val,
		.o_sleep, .o_osc_halt, .o_cycle_done, .o_handled);
	sse_fetch_model u_sse_fetch_model (.i_clk, .i_phase(o_phase),
		.i_sleep(o_sleep), .o_valid(vld), .o_instr(ins));
	task chk(input logic [15:0] s, e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	// bounded wait for the cycle-end pulse, counting watchdog clears
	task wdone;
		for (int i = 0; i < 12; i++) begin
			@(posedge i_clk);
			#1;
			nclr += o_watchdog_clear;
			if (o_cycle_done === 1'h1) return;
		end
		err_total++;
		$display("ERROR %0t: no cycle end", $time);
	endtask
	// queued in Q2 so it is offered at the next Q1, then its own end
	task exec(input logic [13:0] op);
		wdone();
		@(posedge i_clk);
		#1;
		u_sse_fetch_model.put(op);
		nclr = 0;
		wdone();
		wdone();
	endtask
	// W and flags loaded in an idle cycle, well before the next word
	task ldw(input logic [7:0] v, input logic [2:0] fv);
		wdone();
		{i_w_data, i_flags_data, i_w_load, i_flags_load} = {v, fv, 2'h3};
		@(posedge i_clk);
		#1;
		{i_w_load, i_flags_load} = 2'h0;
	endtask
	task end_sim;
		$display("errors %0d compares %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge i_clk);
		#1;
		i_rstn = 1'h1;
		// flags preloaded inverted so every one must be rewritten
		foreach (tv[n]) begin
			{k, w} = tv[n];
			d = k - w;
			f = {k >= w, k[3:0] >= w[3:0], d == 8'h00};
			ldw(w, ~f);
			exec({5'h1E, n[0], k});
			chk(o_w, d);
			chk(o_flags, f);
			chk({o_pwr, o_handled}, 3'h7);
		end
		exec(14'h0064);
		chk({o_w, o_handled, o_sleep}, {d, 2'h0});
		exec(14'h0063);
		chk({o_pwr, o_sleep, o_osc_halt, o_w}, {4'hB, d});
		chk({nclr[1:0], o_watchdog_counter_val}, 10'h100);
		repeat (5) @(posedge i_clk);
		#1;
		chk(o_sleep, 1'h1);
		i_wake = 1'h1;
		@(posedge i_clk);
		#1;
		i_wake = 1'h0;
		ldw(8'h05, 3'h0);
		exec(14'h3C09);
		chk({o_w, o_pwr}, {8'h04, 2'h2});
		end_sim();
	end
	initial begin
		#100000;
		err_total++;
		end_sim();
	end
endmodule
